// ==== can_tx_defs.svh ====
// field positions, word selects and sizes for the transmit mailbox block
`ifndef CAN_TX_DEFS_SVH
`define CAN_TX_DEFS_SVH

// cpu word select within one mailbox
`define WORD_CS          2'h0
`define WORD_ID          2'h1
`define WORD_DATA_HI     2'h2
`define WORD_DATA_LO     2'h3

// control/status word layout
`define CS_CODE_LSB      24
`define CS_IDE_BIT       21
`define CS_RTR_BIT       20
`define CS_LEN_LSB       16

// sizes
`define MAILBOX_COUNT    16
`define MAX_DATA_BYTES   4'h8
`define STD_ID_LSB       18
`define FLAG_RESET       16'h0000

`endif

// ==== can_tx_pkg.sv ====
// types shared by the transmit mailbox block
package can_tx_pkg;

   // mailbox code field values
   typedef enum logic [3:0] {
      RX_INACTIVE = 4'b0000,
      RX_EMPTY    = 4'b0100,
      TX_INACTIVE = 4'b1000,
      TX_REMOTE   = 4'b1010,
      TX_ONCE     = 4'b1100,
      TX_ANSWER   = 4'b1110
   } mailbox_code_t;

endpackage

// ==== tx_code_update.sv ====
// code of a mailbox after its frame went out successfully
`timescale 1ns/1ps
`default_nettype none

module tx_code_update (
   input  wire logic [3:0] code_now,
   input  wire logic       remote_bit,
   output logic      [3:0] code_after
);

   // once-data goes inactive, once-remote becomes empty receive, answer rearms
   assign code_after =
      (code_now == can_tx_pkg::TX_ONCE && !remote_bit) ? can_tx_pkg::TX_INACTIVE : // [RULE2]
      (code_now == can_tx_pkg::TX_ONCE)   ? can_tx_pkg::RX_EMPTY :  // [RULE3] [RULE19]
      (code_now == can_tx_pkg::TX_ANSWER) ? can_tx_pkg::TX_REMOTE : // [RULE5]
      code_now;

endmodule

`default_nettype wire

// ==== tx_arbiter.sv ====
// one-pass scan choosing the lowest key or the lowest mailbox number
`timescale 1ns/1ps
`default_nettype none

module tx_arbiter #(
   parameter int N  = 16,
   parameter int IW = 4
) (
   input  wire logic [N-1:0]    cand,
   input  wire logic [N*32-1:0] keys,
   input  wire logic            lowest_first,
   output logic                 found,
   output logic      [IW-1:0]   idx
);

   logic [31:0]   best_key [N+1];
   logic [IW-1:0] best_idx [N+1];
   logic          best_ok  [N+1];

   assign best_key[0] = 32'h0;
   assign best_idx[0] = '0;
   assign best_ok[0]  = 1'b0;

   // chain in mailbox order; strict compare keeps the lower number on ties
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_scan
         wire take = cand[i] && (!best_ok[i] ||
                     (!lowest_first && keys[i*32 +: 32] < best_key[i])); // [RULE12] [RULE20]
         assign best_key[i+1] = take ? keys[i*32 +: 32] : best_key[i];
         assign best_idx[i+1] = take ? IW'(i) : best_idx[i];
         assign best_ok[i+1]  = best_ok[i] | cand[i];
      end
   endgenerate

   assign found = best_ok[N];
   assign idx   = best_idx[N];

endmodule

`default_nettype wire

// ==== can_tx_mailbox_arbiter.sv ====
// transmit mailboxes, arbitration, move-out and completion bookkeeping
//
// Function
// RULE1: code 1000 mailbox never transmits
// RULE2: 1100 data sends once, returns 1000
// RULE3: 1100 remote sends once, becomes 0100
// RULE4: 1010 remote match joins, code becomes 1110
// RULE5: 1110 sends once, returns 1010; cpu same
// RULE6: software ignores busy bit on transmit
// RULE7: sixteen mailboxes, eight bytes, one flag each
// RULE8: control/status write excludes mailbox this round
// RULE9: software writes cs, id, data, cs
// RULE10: first cs write removes mailbox immediately
// RULE11: completion stores timer, code, flag, interrupt
// RULE12: pick lowest key or lowest mailbox number
// RULE13: key holds rtr and ide at frame positions
// RULE14: arbitrate in crc and error delimiter
// RULE15: intermission rearbitrates after deactivation or writes; code flags any cs write since the last arbitration, used only while no winner is held
// RULE16: arbitrate on idle/bus-off writes, freeze exit
// RULE17: winner copied into hidden serial buffer
// RULE18: send serial buffer, data capped at eight
// RULE19: 0100 is active empty receive mailbox
// RULE20: equal keys pick lower mailbox number
`timescale 1ns/1ps
`default_nettype none
`include "can_tx_defs.svh"

module can_tx_mailbox_arbiter #(
   parameter int NMB = `MAILBOX_COUNT,
   parameter int TW  = 16
) (
   input  wire logic            mclk,
   input  wire logic            reset,
   input  wire logic            cpu_wr,
   input  wire logic            cpu_rd,
   input  wire logic [3:0]      cpu_mailbox,
   input  wire logic [1:0]      cpu_word,
   input  wire logic [31:0]     cpu_wdata,
   output logic      [31:0]     cpu_rdata,
   input  wire logic [NMB-1:0]  flag_clear,
   input  wire logic [NMB-1:0]  mailbox_interrupt_mask,
   input  wire logic            lowest_buffer_first_select,
   input  wire logic [TW-1:0]   free_timer,
   input  wire logic            crc_field,
   input  wire logic            error_delimiter,
   input  wire logic            intermission,
   input  wire logic            buffer_manager_idle,
   input  wire logic            bus_off,
   input  wire logic            freeze,
   input  wire logic            remote_hit,
   input  wire logic [28:0]     remote_id,
   input  wire logic            remote_ide,
   input  wire logic            tx_success,
   output logic                 serial_valid,
   output logic      [28:0]     serial_id,
   output logic                 serial_ide,
   output logic                 serial_rtr,
   output logic      [3:0]      serial_length,
   output logic      [63:0]     serial_data,
   output logic      [NMB-1:0]  mailbox_flag_register,
   output logic                 mailbox_irq
);

   // ==========================================================
   // mailbox storage
   // ==========================================================
   logic [3:0]    code_reg [NMB];
   logic          rtr_reg  [NMB];
   logic          ide_reg  [NMB];
   logic [3:0]    len_reg  [NMB];
   logic [28:0]   id_reg   [NMB];
   logic [63:0]   data_reg [NMB];
   logic [TW-1:0] ts_reg   [NMB];

   logic [NMB-1:0]    cand;
   logic [NMB-1:0]    cs_wr_bits;
   logic [NMB*32-1:0] keys;
   logic [NMB-1:0]    done_bits;
   logic [NMB-1:0]    flag_reg;
   logic [NMB-1:0]    flag_next;

   // ==========================================================
   // winner tracking
   // ==========================================================
   logic       winner_valid_reg;
   logic [3:0] winner_idx_reg;
   logic       winner_deact_reg;
   logic       cs_since_reg;
   logic       crc_d_reg;
   logic       errd_d_reg;
   logic       inter_d_reg;
   logic       freeze_d_reg;

   wire        any_cs_wr = |cs_wr_bits;
   wire        wr_winner = cs_wr_bits[winner_idx_reg];
   wire        done_ok   = tx_success && winner_valid_reg &&
                           !winner_deact_reg && !wr_winner;
   wire [3:0]  win_code  = code_reg[winner_idx_reg];
   wire        win_rtr   = rtr_reg[winner_idx_reg];
   wire [3:0]  upd_code;

   // code after a good transmission for the current winner
   tx_code_update u_code (
      .code_now   (win_code),
      .remote_bit (win_rtr),
      .code_after (upd_code)
   );

   // ==========================================================
   // per-mailbox logic
   // ==========================================================
   genvar i;
   generate
      for (i = 0; i < NMB; i++) begin : g_mailbox
         wire sel     = cpu_wr && (cpu_mailbox == 4'(i));
         wire wr_cs   = sel && (cpu_word == `WORD_CS);
         wire wr_id   = sel && (cpu_word == `WORD_ID);
         wire wr_hi   = sel && (cpu_word == `WORD_DATA_HI);
         wire wr_lo   = sel && (cpu_word == `WORD_DATA_LO);
         wire done_i  = done_ok && (winner_idx_reg == 4'(i));
         // remote request matching this answer mailbox
         wire hit_i   = remote_hit && code_reg[i] == can_tx_pkg::TX_REMOTE &&
                        remote_id == id_reg[i] && remote_ide == ide_reg[i];
         wire [3:0] code_next =
            wr_cs  ? cpu_wdata[`CS_CODE_LSB +: 4] :
            done_i ? upd_code :                                      // [RULE11]
            hit_i  ? can_tx_pkg::TX_ANSWER : code_reg[i];            // [RULE4]

         assign cs_wr_bits[i] = wr_cs;
         assign done_bits[i]  = done_i;
         // 1000 is inactive; a cs write drops the mailbox from this round
         assign cand[i] = ((code_reg[i] == can_tx_pkg::TX_ONCE) ||
                           (code_reg[i] == can_tx_pkg::TX_ANSWER) ||
                           hit_i) && !wr_cs;               // [RULE1] [RULE4] [RULE8] [RULE10]
         // arbitration key laid out as the bits go on the wire
         assign keys[i*32 +: 32] = ide_reg[i] ?
            {id_reg[i][28:18], 1'b1, 1'b1, id_reg[i][17:0], rtr_reg[i]} :
            {id_reg[i][28:18], rtr_reg[i], 1'b0, 19'h0};     // [RULE13]

         // code and control bits
         always_ff @(posedge mclk) begin
            if (reset) begin
               code_reg[i] <= can_tx_pkg::RX_INACTIVE;
               rtr_reg[i]  <= 1'b0;
               ide_reg[i]  <= 1'b0;
               len_reg[i]  <= 4'h0;
            end else begin
               code_reg[i] <= code_next;                     // [RULE5]
               if (wr_cs) begin
                  rtr_reg[i] <= cpu_wdata[`CS_RTR_BIT];
                  ide_reg[i] <= cpu_wdata[`CS_IDE_BIT];
                  len_reg[i] <= cpu_wdata[`CS_LEN_LSB +: 4];
               end
            end
         end

         // identifier, payload and time stamp
         always_ff @(posedge mclk) begin
            if (reset) begin
               id_reg[i]   <= 29'h0;
               data_reg[i] <= 64'h0;
               ts_reg[i]   <= '0;
            end else begin
               if (wr_id)
                  id_reg[i] <= cpu_wdata[28:0];
               if (wr_hi)
                  data_reg[i][63:32] <= cpu_wdata;
               if (wr_lo)
                  data_reg[i][31:0] <= cpu_wdata;
               if (done_i)
                  ts_reg[i] <= free_timer;                   // [RULE11]
            end
         end
      end
   endgenerate

   // ==========================================================
   // arbitration triggers
   // ==========================================================
   wire crc_rise   = crc_field && !crc_d_reg;
   wire errd_rise  = error_delimiter && !errd_d_reg;
   wire inter_rise = intermission && !inter_d_reg;
   wire frz_exit   = freeze_d_reg && !freeze;
   wire arb_fire   = crc_rise || errd_rise ||                           // [RULE14]
                     (inter_rise && (winner_deact_reg ||
                      (!winner_valid_reg && cs_since_reg))) ||          // [RULE15]
                     (any_cs_wr && (buffer_manager_idle || bus_off)) ||
                     frz_exit;                                          // [RULE16]

   wire       arb_found;
   wire [3:0] arb_idx;

   tx_arbiter #(
      .N  (NMB),
      .IW (4)
   ) u_arb (
      .cand         (cand),
      .keys         (keys),
      .lowest_first (lowest_buffer_first_select),
      .found        (arb_found),
      .idx          (arb_idx)
   );

   // edge history of the frame phase inputs and freeze
   always_ff @(posedge mclk) begin
      if (reset) begin
         crc_d_reg    <= 1'b0;
         errd_d_reg   <= 1'b0;
         inter_d_reg  <= 1'b0;
         freeze_d_reg <= 1'b0;
      end else begin
         crc_d_reg    <= crc_field;
         errd_d_reg   <= error_delimiter;
         inter_d_reg  <= intermission;
         freeze_d_reg <= freeze;
      end
   end

   // winner state; a write to the winner after move-out still sends it
   always_ff @(posedge mclk) begin
      if (reset) begin
         winner_valid_reg <= 1'b0;
         winner_idx_reg   <= 4'h0;
         winner_deact_reg <= 1'b0;
         cs_since_reg     <= 1'b0;
      end else begin
         cs_since_reg <= any_cs_wr || (cs_since_reg && !arb_fire);
         if (arb_fire) begin
            winner_valid_reg <= arb_found;
            winner_idx_reg   <= arb_idx;
            winner_deact_reg <= 1'b0;
         end else begin
            winner_deact_reg <= winner_valid_reg && (winner_deact_reg || wr_winner);
            if (tx_success)
               winner_valid_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // move-out into the serial holding buffer
   // ==========================================================
   wire [3:0] win_len_raw = len_reg[arb_idx];
   wire [3:0] win_len_cap = (win_len_raw > `MAX_DATA_BYTES) ?
                            `MAX_DATA_BYTES : win_len_raw;      // [RULE18]

   always_ff @(posedge mclk) begin
      if (reset) begin
         serial_id     <= 29'h0;
         serial_ide    <= 1'b0;
         serial_rtr    <= 1'b0;
         serial_length <= 4'h0;
         serial_data   <= 64'h0;
      end else if (arb_fire && arb_found) begin
         serial_id     <= id_reg[arb_idx];                      // [RULE17]
         serial_ide    <= ide_reg[arb_idx];
         serial_rtr    <= rtr_reg[arb_idx];
         serial_length <= win_len_cap;
         serial_data   <= data_reg[arb_idx];
      end
   end

   assign serial_valid = winner_valid_reg;                       // [RULE18]

   // ==========================================================
   // completion flags and interrupt
   // ==========================================================
   assign flag_next = (flag_reg & ~flag_clear) | done_bits;      // [RULE7] [RULE11]

   always_ff @(posedge mclk) begin
      if (reset)
         flag_reg <= `FLAG_RESET;
      else
         flag_reg <= flag_next;
   end

   assign mailbox_flag_register = flag_reg;
   assign mailbox_irq = |(flag_reg & mailbox_interrupt_mask);   // [RULE11]

   // ==========================================================
   // cpu read port
   // ==========================================================
   wire [3:0]  rd_code = code_reg[cpu_mailbox];
   wire [31:0] rd_cs   = {4'h0, rd_code, 2'h0, ide_reg[cpu_mailbox], rtr_reg[cpu_mailbox],
                          len_reg[cpu_mailbox], 16'(ts_reg[cpu_mailbox])};
   wire [31:0] rd_word = (cpu_word == `WORD_CS) ? rd_cs :
                         (cpu_word == `WORD_ID) ? {3'h0, id_reg[cpu_mailbox]} :
                         (cpu_word == `WORD_DATA_HI) ? data_reg[cpu_mailbox][63:32] :
                         data_reg[cpu_mailbox][31:0];

   always_ff @(posedge mclk) begin
      if (reset)
         cpu_rdata <= 32'h0;
      else if (cpu_rd)
         cpu_rdata <= rd_word;
   end

   // ==========================================================
   // checks
   // ==========================================================
   sequence s_once_done;
      done_ok && win_code == can_tx_pkg::TX_ONCE;
   endsequence

   a_inactive_excluded: assert property (@(posedge mclk) disable iff (reset) // [RULE1]
      arb_fire && arb_found |-> code_reg[arb_idx] != can_tx_pkg::TX_INACTIVE)
      else $error("inactive mailbox won arbitration");

   a_data_once: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
      s_once_done ##0 !win_rtr |=>
      code_reg[$past(winner_idx_reg)] == can_tx_pkg::TX_INACTIVE && !serial_valid)
      else $error("data once mailbox did not return inactive");

   a_remote_once: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      s_once_done ##0 win_rtr |=> code_reg[$past(winner_idx_reg)] == can_tx_pkg::RX_EMPTY)
      else $error("remote mailbox did not become empty receive");

   a_answer_rearm: assert property (@(posedge mclk) disable iff (reset) // [RULE5]
      done_ok && win_code == can_tx_pkg::TX_ANSWER |=>
      code_reg[$past(winner_idx_reg)] == can_tx_pkg::TX_REMOTE)
      else $error("answer mailbox did not rearm");

   a_write_excludes: assert property (@(posedge mclk) disable iff (reset) // [RULE10]
      arb_fire && any_cs_wr |-> !cs_wr_bits[arb_idx] || !arb_found)
      else $error("mailbox under cs write took part in arbitration");

   a_completion_book: assert property (@(posedge mclk) disable iff (reset) // [RULE11]
      done_ok |=> flag_reg[$past(winner_idx_reg)] &&
      ts_reg[$past(winner_idx_reg)] == $past(free_timer))
      else $error("completion bookkeeping missing");

   a_lowest_number: assert property (@(posedge mclk) disable iff (reset) // [RULE12]
      arb_found && lowest_buffer_first_select |->
      (cand & ((16'h1 << arb_idx) - 16'h1)) == 16'h0)
      else $error("lower numbered candidate skipped");

   a_crc_trigger: assert property (@(posedge mclk) disable iff (reset) // [RULE14]
      crc_rise && |cand |=> serial_valid)
      else $error("no move-out after crc field trigger");

   a_freeze_exit: assert property (@(posedge mclk) disable iff (reset) // [RULE16]
      frz_exit && |cand |=> serial_valid)
      else $error("leaving freeze did not move out a candidate");

   a_length_cap: assert property (@(posedge mclk) disable iff (reset) // [RULE18]
      serial_valid |-> serial_length <= `MAX_DATA_BYTES)
      else $error("serial buffer length above eight");

endmodule

`default_nettype wire

// ==== can_bus_node_model.sv ====
// behavioural far-side bus node: frame phases and transmit completion
`timescale 1ns/1ps
`default_nettype none

module can_bus_node_model (
   input  wire logic       mclk,
   input  wire logic       go,
   input  wire logic [1:0] kind,
   input  wire logic       frame_ready,
   output logic            crc_field,
   output logic            error_delimiter,
   output logic            intermission,
   output var logic        tx_success,
   output var logic        busy
);
   // =====================================================
   // phase levels: crc, error delimiter, intermission
   logic [2:0] ph;

   assign crc_field       = ph[2];
   assign error_delimiter = ph[1];
   assign intermission    = ph[0];

   // one phase level held two cycles, moved at the falling edge
   task automatic step(input logic [2:0] p);
      @(negedge mclk);
      ph = p;
      repeat (2) @(negedge mclk);
      ph = 3'h0;
   endtask

   // kind 0 good frame, 1 error frame, 2 intermission only
   initial begin
      ph = 3'h0;
      tx_success = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge mclk);
         if (go) begin
            busy = 1'b1;
            if (kind == 2'h0) begin
               step(3'h4);
               @(negedge mclk);
               tx_success = frame_ready; // only a held frame can complete
               @(negedge mclk);
               tx_success = 1'b0;
            end
            if (kind == 2'h1) begin
               step(3'h2);
            end
            step(3'h1);
            busy = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the transmit mailbox block
`timescale 1ns/1ps
`default_nettype none

module tb;
   typedef struct packed {
      logic [3:0] slot;
      logic [3:0] code;
      logic       remote;
      logic [3:0] len;
      logic       msk;
      logic       v;
      logic [3:0] elen;
      logic [3:0] ecode;
   } row_t;

   logic        mclk, reset, cpu_wr, cpu_rd, low_first, idle, freeze, rhit, go, boff, ride;
   logic        crc, edel, inter, txok, busy, sv, srem, irq, sside;
   logic [3:0]  mbox, slen;
   logic [1:0]  cpu_word, kind;
   logic [31:0] cpu_wdata, cpu_rdata, rd_val;
   logic [15:0] fclr, mask, timer, flags, ef;
   logic [28:0] rid, sid;
   logic [63:0] sdata;
   int          n_mismatch, tests_run;
   row_t        rows [5];

   // =====================================================
   // clock and the two parties
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   can_tx_mailbox_arbiter uut (.mclk(mclk), .reset(reset), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
      .cpu_mailbox(mbox), .cpu_word(cpu_word), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .flag_clear(fclr), .mailbox_interrupt_mask(mask), .lowest_buffer_first_select(low_first),
      .free_timer(timer), .crc_field(crc), .error_delimiter(edel), .intermission(inter),
      .buffer_manager_idle(idle), .bus_off(boff), .freeze(freeze), .remote_hit(rhit),
      .remote_id(rid), .remote_ide(ride), .tx_success(txok), .serial_valid(sv),
      .serial_id(sid), .serial_ide(sside), .serial_rtr(srem), .serial_length(slen),
      .serial_data(sdata), .mailbox_flag_register(flags), .mailbox_irq(irq));

   can_bus_node_model node (.mclk(mclk), .go(go), .kind(kind), .frame_ready(sv),
      .crc_field(crc), .error_delimiter(edel), .intermission(inter), .tx_success(txok),
      .busy(busy));

   // =====================================================
   // compare, report and bus tasks
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   function automatic logic [31:0] cs(input logic [3:0] c, input logic r, input logic [3:0] l);
      return {4'h0, c, 3'h0, r, l, 16'h0};
   endfunction

   task automatic wr(input logic [3:0] s, input logic [1:0] w, input logic [31:0] d);
      @(negedge mclk);
      cpu_wr = 1'b1;
      mbox = s;
      cpu_word = w;
      cpu_wdata = d;
      @(negedge mclk);
      cpu_wr = 1'b0;
   endtask

   // read the control/status word; answer lands one edge later
   // receive codes 0000 and 0100 are read back too, and no busy bit is looked at
   task automatic rd_cs(input logic [3:0] s);
      @(negedge mclk);
      cpu_rd = 1'b1;
      mbox = s;
      cpu_word = 2'h0;
      @(negedge mclk);
      cpu_rd = 1'b0;
      rd_val = cpu_rdata;
   endtask

   // hold inactive, id, data tagged with the slot, then activate
   task automatic prep(input logic [3:0] s, c, input logic r, input logic [3:0] l,
                       input logic [10:0] id);
      wr(s, 2'h0, cs(4'h8, 1'b0, 4'h0));
      wr(s, 2'h1, {3'h0, id, 18'h0});
      wr(s, 2'h2, {28'h0, s});
      wr(s, 2'h3, 32'h0);
      wr(s, 2'h0, cs(c, r, l));
   endtask

   task automatic thaw();
      @(negedge mclk);
      freeze = 1'b1;
      @(negedge mclk);
      freeze = 1'b0;
      repeat (3) @(negedge mclk);
   endtask

   task automatic frame(input logic [1:0] k);
      int n;
      @(negedge mclk);
      go = 1'b1;
      kind = k;
      @(negedge mclk);
      go = 1'b0;
      for (n = 0; n < 40 && busy; n++) @(negedge mclk);
      @(negedge mclk);
   endtask

   task automatic hit(input logic [10:0] id);
      @(negedge mclk);
      rhit = 1'b1;
      rid = {id, 18'h0};
      @(negedge mclk);
      rhit = 1'b0;
   endtask

   task automatic win(input logic [3:0] w);
      chk("winner", {59'h0, 1'b1, w}, {59'h0, sv, sdata[35:32]});
   endtask

   // two ready mailboxes, freeze exit picks one, both then held inactive
   task automatic duel(input logic [3:0] a, b, input logic ra, rb, input logic [10:0] ia, ib,
                       input logic lf, input logic [3:0] w);
      prep(a, 4'hc, ra, 4'h1, ia);
      prep(b, 4'hc, rb, 4'h1, ib);
      low_first = lf;
      thaw();
      win(w);
      wr(a, 2'h0, cs(4'h8, 1'b0, 4'h0));
      wr(b, 2'h0, cs(4'h8, 1'b0, 4'h0));
   endtask

   // =====================================================
   // watchdog
   initial begin
      #100000;
      n_mismatch++;
      final_report();
   end

   // =====================================================
   // main sequence
   initial begin
      {reset, cpu_wr, cpu_rd, low_first, idle, freeze, rhit, go} = 8'h80;
      {mbox, cpu_word, kind, cpu_wdata, fclr, mask, timer, rid, boff, ride} = '0;
      rows[0] = '{4'h1, 4'hc, 1'b0, 4'h4, 1'b1, 1'b1, 4'h4, 4'h8};
      rows[1] = '{4'h2, 4'hc, 1'b1, 4'h0, 1'b0, 1'b1, 4'h0, 4'h4};
      rows[2] = '{4'h4, 4'he, 1'b0, 4'hf, 1'b1, 1'b1, 4'h8, 4'ha};
      rows[3] = '{4'hf, 4'h8, 1'b1, 4'h8, 1'b1, 1'b0, 4'h8, 4'h8};
      rows[4] = '{4'h0, 4'ha, 1'b0, 4'h2, 1'b1, 1'b0, 4'h2, 4'ha};
      repeat (16) @(negedge mclk);
      reset = 1'b0;
      rd_cs(4'h0);
      chk("reset", 64'h0, {14'h0, rd_val, sv, flags, irq});
      idle = 1'b1;
      foreach (rows[i]) begin
         mask = rows[i].msk ? 16'h1 << rows[i].slot : 16'h0;
         ef = rows[i].v ? 16'h1 << rows[i].slot : 16'h0;
         timer = 16'h1230 + 16'(i);
         prep(rows[i].slot, rows[i].code, rows[i].remote, rows[i].len, 11'h10 + 11'(i));
         @(negedge mclk);
         chk("valid", 64'h0, {63'h0, sv});
         thaw();
         chk("valid", {63'h0, rows[i].v}, {63'h0, sv});
         if (rows[i].v) begin
            chk("frame", {26'h0, 11'h10 + 11'(i), 18'h0, rows[i].remote, rows[i].elen,
                rows[i].slot}, {26'h0, sid, srem, slen, sdata[35:32]});
         end
         frame(2'h0);
         chk("flags", {47'h0, ef, rows[i].v & rows[i].msk}, {47'h0, flags, irq});
         rd_cs(rows[i].slot);
         chk("code", {60'h0, rows[i].ecode}, {60'h0, rd_val[27:24]});
         if (rows[i].v) begin
            chk("stamp", {48'h0, timer}, {48'h0, rd_val[15:0]});
         end
         @(negedge mclk);
         fclr = 16'hffff;
         @(negedge mclk);
         fclr = 16'h0;
      end
      idle = 1'b0;
      mask = 16'hffff;
      duel(4'h3, 4'h5, 1'b0, 1'b0, 11'h200, 11'h100, 1'b0, 4'h5);
      duel(4'h3, 4'h5, 1'b0, 1'b0, 11'h200, 11'h100, 1'b1, 4'h3);
      duel(4'h7, 4'h9, 1'b0, 1'b0, 11'h150, 11'h150, 1'b0, 4'h7);
      duel(4'ha, 4'hb, 1'b1, 1'b0, 11'h150, 11'h150, 1'b0, 4'hb);
      low_first = 1'b0;
      // remote request answering
      prep(4'hc, 4'ha, 1'b0, 4'h2, 11'h0a0);
      hit(11'h0a1);
      rd_cs(4'hc);
      chk("code", 64'ha, {60'h0, rd_val[27:24]});
      ride = 1'b1;
      hit(11'h0a0);
      ride = 1'b0;
      rd_cs(4'hc);
      chk("code", 64'ha, {60'h0, rd_val[27:24]});
      hit(11'h0a0);
      rd_cs(4'hc);
      chk("code", 64'he, {60'h0, rd_val[27:24]});
      thaw();
      win(4'hc);
      frame(2'h0);
      rd_cs(4'hc);
      chk("code", 64'ha, {60'h0, rd_val[27:24]});
      // trigger points while the manager is busy
      prep(4'h6, 4'hc, 1'b0, 4'h1, 11'h300);
      chk("valid", 64'h0, {63'h0, sv});
      frame(2'h2);
      win(4'h6);
      prep(4'h8, 4'hc, 1'b0, 4'h1, 11'h080);
      frame(2'h2);
      win(4'h6);
      frame(2'h1);
      win(4'h8);
      wr(4'h8, 2'h0, cs(4'h8, 1'b0, 4'h0));
      frame(2'h2);
      win(4'h6);
      fclr = 16'hffff;
      @(negedge mclk);
      fclr = 16'h0;
      prep(4'hd, 4'hc, 1'b0, 4'h1, 11'h001);
      frame(2'h0);
      chk("flags", 64'h2000, {48'h0, flags});
      // cs write exclusion, bus-off trigger, extended keys
      idle = 1'b1;
      wr(4'h6, 2'h0, cs(4'hc, 1'b0, 4'h1));
      chk("valid", 64'h0, {63'h0, sv});
      idle = 1'b0;
      boff = 1'b1;
      wr(4'h8, 2'h0, cs(4'h8, 1'b0, 4'h0));
      win(4'h6);
      boff = 1'b0;
      prep(4'h1, 4'hc, 1'b0, 4'h1, 11'h150);
      wr(4'h1, 2'h0, cs(4'hc, 1'b0, 4'h1) | 32'h0020_0000);
      prep(4'h2, 4'hc, 1'b0, 4'h1, 11'h150);
      thaw();
      win(4'h2);
      wr(4'h2, 2'h0, cs(4'h8, 1'b0, 4'h0));
      thaw();
      win(4'h1);
      chk("ide", 64'h1, {63'h0, sside});
      final_report();
   end
endmodule
`default_nettype wire
